// [design/sbcspi_regmap.sv]
`timescale 1ns/1ns
`default_nettype none
module sbcspi_regmap (
    input wire logic i_sys_clk, // System clock, 10 MHz
    input wire logic i_resetn, // Power-on reset, async, active low
    input wire logic i_spi_cs_n, // Chip select pin, active low
    input wire logic i_spi_sclk, // Serial clock pin
    input wire logic i_spi_mosi, // Serial data from master
    input wire sbcspi_pkg::sbcspi_stat_t i_status, // Live device status flags
    output logic o_spi_miso, // Serial data to master
    output logic o_spi_miso_oe, // High while reply pin is driven
    output sbcspi_pkg::sbcspi_ctrl_t o_ctrl, // Control register contents
    output sbcspi_pkg::sbcspi_mode_t o_mode, // Selected operating state
    output logic o_dog_clear, // One-cycle watchdog clear pulse
    output logic o_driver_shutdown // Drivers off on supply overvoltage
);
    import sbcspi_pkg::*;

    localparam int SYNC_W = 3 + $bits(sbcspi_stat_t);
    localparam logic [SYNC_W-1:0] SYNC_RESET = {1'b1, {(SYNC_W - 1){1'b0}}};

    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_out;
    logic cs_n_s;
    logic sclk_s;
    logic mosi_s;
    sbcspi_stat_t stat_s;

    logic cs_n_d_q;
    logic sclk_d_q;
    logic [3:0] fall_cnt_q;
    logic [2:0] rise_cnt_q;
    logic [7:0] rx_q;
    logic [3:0] addr_q;
    logic power_loss_q;
    sbcspi_stat_t stat_snap_q;
    logic [3:0] volt_snap_q;
    logic [2:0] sum_snap_q;
    logic miso_q;
    logic miso_oe_q;
    sbcspi_ctrl_t ctrl_q;
    sbcspi_ctrl_t ctrl_d;
    sbcspi_mode_t mode_q;
    sbcspi_mode_t mode_d;
    logic dog_clear_q;
    logic shutdown_q;

    // Pins and status arrive from outside this clock domain
    assign sync_in = {i_spi_cs_n, i_spi_sclk, i_spi_mosi, i_status};

    sbcspi_sync #(
        .WIDTH(SYNC_W),
        .RESET_VAL(SYNC_RESET)
    ) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_resetn(i_resetn),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    assign {cs_n_s, sclk_s, mosi_s, stat_s} = sync_out;

    // Reply selection by the address nibble
    function automatic logic [3:0] status_sel(
        input logic [3:0] addr,
        input sbcspi_stat_t st,
        input logic [3:0] volt,
        input logic wake_en
    );
        logic [3:0] r;
        r = 4'h0;
        case (addr)
            ADDR_MODE: r = volt;
            ADDR_VOLT: r = volt;
            ADDR_WAKE_CTRL, ADDR_WAKE_STAT: r = {3'h0, st.wake_input_state & wake_en};
            ADDR_BUS_CTRL, ADDR_BUS_STAT: r = st.bus_fault;
            ADDR_SW_CTRL, ADDR_SW_STAT: r = st.switch_fault;
            ADDR_TIMING, ADDR_DOG_STAT: r = st.dog_status;
            ADDR_IRQ_MASK, ADDR_IRQ_SRC: r = st.irq_source;
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // Edge detection on the synchronised pins
    wire cs_fall = cs_n_d_q & ~cs_n_s;
    wire cs_rise = ~cs_n_d_q & cs_n_s;
    wire sclk_rise = ~cs_n_s & sclk_s & ~sclk_d_q;
    wire sclk_fall = ~cs_n_s & ~sclk_s & sclk_d_q;

    wire [3:0] volt_w = {
        stat_s.supply_overvoltage_flag,
        stat_s.supply_undervoltage_flag,
        stat_s.regulator_temp_warning,
        power_loss_q
    };

    wire voltage_summary_flag = |volt_w;
    wire bus_summary_flag = |stat_s.bus_fault;
    wire switch_summary_flag = |stat_s.switch_fault;

    // summary nibble on top, bit 4 left at zero
    wire [7:0] reply_w = {
        sum_snap_q,
        1'b0,
        status_sel(addr_q, stat_snap_q, volt_snap_q, ctrl_q.wake_input_enable)
    };

    wire frame_ok = cs_rise & (fall_cnt_q == FRAME_BITS);
    wire [3:0] wr_addr = rx_q[7:4];
    wire [3:0] wr_data = rx_q[3:0];
    wire wr_mode = frame_ok & (wr_addr == ADDR_MODE);
    wire volt_access = frame_ok & ((wr_addr == ADDR_MODE) | (wr_addr == ADDR_VOLT));

    // sample on falling clock, count the samples
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            cs_n_d_q <= 1'b1;
            sclk_d_q <= 1'b0;
            fall_cnt_q <= 4'h0;
            rise_cnt_q <= 3'h0;
            rx_q <= 8'h00;
            addr_q <= 4'h0;
        end
        else
        begin
            cs_n_d_q <= cs_n_s;
            sclk_d_q <= sclk_s;
            if (cs_fall)
            begin
                fall_cnt_q <= 4'h0;
                rise_cnt_q <= 3'h0;
            end
            else
            begin
                if (sclk_fall && fall_cnt_q != COUNT_MAX)
                    fall_cnt_q <= fall_cnt_q + 4'h1;
                if (sclk_rise)
                    rise_cnt_q <= rise_cnt_q + 3'h1;
            end
            if (sclk_fall)
                rx_q <= {rx_q[6:0], mosi_s};
            // Address held once complete, control bits keep shifting past it
            if (sclk_fall && fall_cnt_q == ADDR_FALLS - 4'h1)
                addr_q <= {rx_q[2:0], mosi_s};
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            stat_snap_q <= '0;
            volt_snap_q <= 4'h0;
            sum_snap_q <= 3'h0;
        end
        else if (cs_fall)
        begin
            stat_snap_q <= stat_s;
            volt_snap_q <= volt_w;
            sum_snap_q <= {voltage_summary_flag, bus_summary_flag, switch_summary_flag};
        end
    end

    // reply pin released while select is high
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end
        else
        begin
            miso_oe_q <= ~cs_n_s;
            if (cs_fall)
                miso_q <= voltage_summary_flag;
            else if (sclk_rise)
                miso_q <= reply_w[~rise_cnt_q];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            power_loss_q <= POWER_LOSS_RESET;
        else if (volt_access)
            power_loss_q <= 1'b0;
    end

    always_comb
    begin
        ctrl_d = ctrl_q;
        if (frame_ok)
        begin
            case (wr_addr)
                ADDR_MODE:
                begin
                    ctrl_d.overvoltage_shutdown_enable = wr_data[SHUTDOWN_EN_BIT];
                    ctrl_d.bus_pullup_enable = wr_data[PULLUP_BIT];
                end
                ADDR_WAKE_CTRL: ctrl_d.wake_input_enable = wr_data[WAKE_EN_BIT];
                ADDR_BUS_CTRL: ctrl_d.bus_control = wr_data;
                ADDR_SW_CTRL: ctrl_d.switch_control = wr_data;
                ADDR_TIMING:
                begin
                    if (wr_data[PERIOD_SEL_BIT])
                        ctrl_d.cyclic_period = wr_data[2:0];
                    else
                        ctrl_d.dog_period = wr_data[2:0];
                end
                ADDR_MUX: ctrl_d.analog_mux_control = wr_data;
                ADDR_CONFIG: ctrl_d.configuration = wr_data[3:2];
                ADDR_IRQ_MASK: ctrl_d.interrupt_mask = {
                    wr_data[SWITCH_MASK_BIT],
                    wr_data[BUS_MASK_BIT],
                    wr_data[VOLT_MASK_BIT]
                };
                default: ctrl_d = ctrl_q;
            endcase
        end
    end

    always_comb
    begin
        mode_d = mode_q;
        if (wr_mode)
        begin
            case (wr_data[1:0])
                2'b01: mode_d = SBCSPI_MODE_STOP;
                2'b10: mode_d = SBCSPI_MODE_SLEEP;
                default: mode_d = SBCSPI_MODE_NORMAL;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ctrl_q <= CTRL_RESET;
            mode_q <= SBCSPI_MODE_NORMAL;
            dog_clear_q <= 1'b0;
            shutdown_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            mode_q <= mode_d;
            dog_clear_q <= wr_mode & (wr_data[1:0] == MODE_SEL_DOG_CLEAR);
            shutdown_q <= ctrl_q.overvoltage_shutdown_enable
                & stat_s.supply_overvoltage_flag;
        end
    end

    assign o_spi_miso = miso_q;
    assign o_spi_miso_oe = miso_oe_q;
    assign o_ctrl = ctrl_q;
    assign o_mode = mode_q;
    assign o_dog_clear = dog_clear_q;
    assign o_driver_shutdown = shutdown_q;

    AST_SUMMARY_FIRST: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        sclk_rise && rise_cnt_q == 3'h0 |=> o_spi_miso == sum_snap_q[2])
        else $error("first reply bit is not the voltage summary");

    AST_VOLT_SUMMARY: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        $fell(cs_n_s) |=> sum_snap_q[2] == (|$past(volt_w)))
        else $error("voltage summary snapshot wrong");

    AST_BUS_SUMMARY: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        $fell(cs_n_s) |=> sum_snap_q[1] == (|$past(stat_s.bus_fault)))
        else $error("bus summary snapshot wrong");

    AST_SW_SUMMARY: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        $fell(cs_n_s) |=> sum_snap_q[0] == (|$past(stat_s.switch_fault)))
        else $error("switch summary snapshot wrong");

    AST_MODE_REPLY: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        sclk_rise && rise_cnt_q == 3'h4 && rx_q[3:0] == ADDR_MODE
        |=> o_spi_miso == volt_snap_q[3])
        else $error("mode write did not return voltage flags");

    AST_DOG_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        wr_mode && wr_data[1:0] == 2'h3
        |=> o_dog_clear && o_mode == SBCSPI_MODE_NORMAL ##1 !o_dog_clear)
        else $error("watchdog clear not a single pulse in normal mode");

    AST_SHUTDOWN: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        !ctrl_q.overvoltage_shutdown_enable |=> !o_driver_shutdown)
        else $error("shutdown asserted while disabled");

    AST_POWER_LOSS_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        volt_access |=> !power_loss_q [*2])
        else $error("power loss flag survived access");

    AST_BAD_FRAME: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        cs_rise && fall_cnt_q != FRAME_BITS |=> $stable(ctrl_q) && $stable(mode_q))
        else $error("incomplete frame changed a register");

    AST_MISO_RELEASE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        cs_n_s |=> !o_spi_miso_oe)
        else $error("reply pin driven while deselected");

    AST_ODD_STABLE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
        frame_ok && wr_addr[0] && wr_addr != ADDR_CONFIG |=> $stable(ctrl_q) && $stable(mode_q))
        else $error("read-only address changed control");

endmodule
`default_nettype wire

// [design/sbcspi_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module sbcspi_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_sys_clk, // System clock
    input wire logic i_resetn, // Async reset, active low
    input wire logic [WIDTH-1:0] i_async, // Inputs from outside the clock domain
    output logic [WIDTH-1:0] o_sync // Two-stage synchronised copy
);
    import sbcspi_pkg::*;

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage
    always_ff @(posedge i_sys_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            meta_q <= RESET_VAL;
            o_sync <= RESET_VAL;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule
`default_nettype wire

// [include/sbcspi_pkg.sv]
// Operation
// - Reply upper nibble carries summary bits always
// - Voltage summary is OR of voltage flags
// - Bus summary is OR of bus flags
// - Switch summary is OR of switch flags
// - Mode control write returns voltage flags
// - Mode bits select normal, stop, sleep, clear
// - Overvoltage shutdown enable, resets to one
// - Bus pull-up enable, resets to one
// - Voltage status readable at addresses 0, 1
// - Over and under voltage follow supply
// - Regulator temperature warning follows threshold
// - Power loss flag set by reset
// - Access to 0 or 1 clears power-loss
// - Wake control at 2, status at 3
// - Bus control at 4, faults at 5
// - Switch control at 6, flags at 7
// - Timing write at A, dog status B
// - Analog mux control write-only at C
// - Configuration write-only at D, two bits
// - Interrupt mask at E, source at F
// - Frame: address, control in; summary, status out
// - Frame valid only with exactly eight samples
// - Write on select rise; reply tri-stated idle
// - Shift on clock rise, sample on fall
package sbcspi_pkg;

    localparam logic [3:0] ADDR_MODE = 4'h0;
    localparam logic [3:0] ADDR_VOLT = 4'h1;
    localparam logic [3:0] ADDR_WAKE_CTRL = 4'h2;
    localparam logic [3:0] ADDR_WAKE_STAT = 4'h3;
    localparam logic [3:0] ADDR_BUS_CTRL = 4'h4;
    localparam logic [3:0] ADDR_BUS_STAT = 4'h5;
    localparam logic [3:0] ADDR_SW_CTRL = 4'h6;
    localparam logic [3:0] ADDR_SW_STAT = 4'h7;
    localparam logic [3:0] ADDR_TIMING = 4'ha;
    localparam logic [3:0] ADDR_DOG_STAT = 4'hb;
    localparam logic [3:0] ADDR_MUX = 4'hc;
    localparam logic [3:0] ADDR_CONFIG = 4'hd;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'he;
    localparam logic [3:0] ADDR_IRQ_SRC = 4'hf;

    // Field positions inside the four control bits of a frame
    localparam int SHUTDOWN_EN_BIT = 3;
    localparam int PULLUP_BIT = 2;
    localparam int WAKE_EN_BIT = 0;
    localparam int PERIOD_SEL_BIT = 3;
    localparam int SWITCH_MASK_BIT = 3;
    localparam int BUS_MASK_BIT = 1;
    localparam int VOLT_MASK_BIT = 0;

    localparam logic [3:0] FRAME_BITS = 4'h8;
    localparam logic [3:0] ADDR_FALLS = 4'h4;
    localparam logic [3:0] COUNT_MAX = 4'hf;
    localparam logic [1:0] MODE_SEL_DOG_CLEAR = 2'h3;
    localparam logic POWER_LOSS_RESET = 1'h1;

    typedef enum logic [1:0] {
        SBCSPI_MODE_NORMAL = 2'b00,
        SBCSPI_MODE_STOP = 2'b01,
        SBCSPI_MODE_SLEEP = 2'b10
    } sbcspi_mode_t;

    typedef struct packed {
        logic overvoltage_shutdown_enable;
        logic bus_pullup_enable;
        logic wake_input_enable;
        logic [3:0] bus_control;
        logic [3:0] switch_control;
        logic [2:0] dog_period;
        logic [2:0] cyclic_period;
        logic [3:0] analog_mux_control;
        logic [1:0] configuration;
        logic [2:0] interrupt_mask;
    } sbcspi_ctrl_t;

    typedef struct packed {
        logic supply_overvoltage_flag;
        logic supply_undervoltage_flag;
        logic regulator_temp_warning;
        logic wake_input_state;
        logic [3:0] bus_fault;
        logic [3:0] switch_fault;
        logic [3:0] dog_status;
        logic [3:0] irq_source;
    } sbcspi_stat_t;

    localparam sbcspi_ctrl_t CTRL_RESET = '{
        overvoltage_shutdown_enable: 1'h1,
        bus_pullup_enable: 1'h1,
        wake_input_enable: 1'h1,
        bus_control: 4'h0,
        switch_control: 4'h0,
        dog_period: 3'h0,
        cyclic_period: 3'h0,
        analog_mux_control: 4'h0,
        configuration: 2'h0,
        interrupt_mask: 3'h0
    };

endpackage

// [sim/sbcspi_master.sv]
`timescale 1ns/1ns
`default_nettype none
module sbcspi_master (
    input wire logic i_sys_clk, // Bench clock, edges placed on its fall
    input wire logic i_miso, // Reply wire, z while released
    output logic o_cs_n, // Chip select, active low
    output logic o_sclk, // Serial clock, idle low
    output logic o_mosi // Serial data to the device
);
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end

    // one byte out, chosen count of sampling edges
    // callers keep the reserved addresses out
    task automatic frame(input logic [3:0] addr, input logic [3:0] data, input int falls,
                         input int half, output logic [7:0] reply);
        logic [7:0] tx;
        tx = {addr, data};
        reply = 8'h00;
        @(negedge i_sys_clk);
        o_cs_n = 1'b0;
        // Setup well over 1 us before the first clock rise
        repeat (12) @(negedge i_sys_clk);
        for (int i = 0; i < falls; i++)
        begin
            // shift on rise, sample on fall
            o_sclk = 1'b1;
            o_mosi = (i < 8) ? tx[7 - i] : ~o_mosi;
            repeat (half) @(negedge i_sys_clk);
            o_sclk = 1'b0;
            reply = {reply[6:0], i_miso};
            repeat (half) @(negedge i_sys_clk);
        end
        repeat (4) @(negedge i_sys_clk);
        o_cs_n = 1'b1;
        // A released line shows a flipped level, never a stale one
        o_mosi = ~o_mosi;
        repeat (12) @(negedge i_sys_clk);
    endtask
endmodule
`default_nettype wire

// [sim/sbcspi_regmap_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module sbcspi_regmap_tb;
    import sbcspi_pkg::*;
    logic sys_clk;
    logic resetn;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic dog_clear;
    logic drv_off;
    wire logic miso_w;
    sbcspi_stat_t status;
    sbcspi_ctrl_t ctrl;
    sbcspi_ctrl_t exp_ctrl;
    sbcspi_mode_t mode;
    logic [7:0] rep;
    logic [3:0] odd_a [6] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'hb, 4'hf};
    int mismatches;
    int cmp_count;
    int dog_pulses = 0;
    int dog_base;

    assign miso_w = miso_oe ? miso : 1'bz;

    initial sys_clk = 1'b0;
    always #50 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (dog_clear === 1'b1) dog_pulses++;

    sbcspi_regmap sbcspi_regmap_i (
        .i_sys_clk(sys_clk), .i_resetn(resetn), .i_spi_cs_n(cs_n), .i_spi_sclk(sclk),
        .i_spi_mosi(mosi), .i_status(status), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe),
        .o_ctrl(ctrl), .o_mode(mode), .o_dog_clear(dog_clear), .o_driver_shutdown(drv_off)
    );
    sbcspi_master sbcspi_master_i (
        .i_sys_clk(sys_clk), .i_miso(miso_w), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi)
    );

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_ctrl(input sbcspi_ctrl_t got, input sbcspi_ctrl_t exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Status settles through the synchronisers before chip select falls
    task automatic xfer(input logic [3:0] a, input logic [3:0] d, input sbcspi_stat_t st,
                        input int falls, input int half);
        status = st;
        repeat (4) @(negedge sys_clk);
        sbcspi_master_i.frame(a, d, falls, half, rep);
        cmp8({7'h0, miso_oe}, 8'h00);
    endtask

    task automatic rd(input logic [3:0] a, input sbcspi_stat_t st, input logic [7:0] exp);
        xfer(a, 4'h0, st, 8, 4);
        cmp8(rep, exp);
    endtask

    task automatic wr(input logic [3:0] a, input logic [3:0] d, input sbcspi_stat_t st,
                      input logic [7:0] exp);
        xfer(a, d, st, 8, 4);
        cmp8(rep, exp);
        cmp_ctrl(ctrl, exp_ctrl);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        resetn = 1'b0;
        status = '0;
        mismatches = 0;
        cmp_count = 0;
        repeat (20) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        exp_ctrl = CTRL_RESET;
        cmp_ctrl(ctrl, CTRL_RESET);
        cmp8({6'h0, mode}, 8'h00);
        rd(ADDR_VOLT, '0, 8'h81);
        rd(ADDR_VOLT, '0, 8'h00);
        $display("test power_loss done");

        for (int m = 0; m < 4; m++)
        begin
            dog_base = dog_pulses;
            xfer(ADDR_MODE, {2'b11, 2'(m)}, '{supply_overvoltage_flag: 1'b1, default: '0},
                 8, 4);
            cmp8(rep, 8'h88);
            cmp8({6'h0, mode}, (m == 3) ? 8'h00 : 8'(m));
            cmp8(8'(dog_pulses - dog_base), (m == 3) ? 8'h01 : 8'h00);
            cmp8({7'h0, drv_off}, 8'h01);
        end
        exp_ctrl.overvoltage_shutdown_enable = 1'b0;
        exp_ctrl.bus_pullup_enable = 1'b0;
        wr(ADDR_MODE, 4'h0, '{supply_overvoltage_flag: 1'b1, default: '0}, 8'h88);
        cmp8({7'h0, drv_off}, 8'h00);
        $display("test mode_control done");

        rd(ADDR_VOLT, '{supply_undervoltage_flag: 1'b1, default: '0}, 8'h84);
        rd(ADDR_VOLT, '{regulator_temp_warning: 1'b1, default: '0}, 8'h82);
        rd(ADDR_BUS_STAT, '{bus_fault: 4'h2, default: '0}, 8'h42);
        rd(ADDR_SW_STAT, '{switch_fault: 4'h9, default: '0}, 8'h29);
        rd(ADDR_DOG_STAT, '{dog_status: 4'h5, default: '0}, 8'h05);
        rd(ADDR_IRQ_SRC, '{irq_source: 4'ha, default: '0}, 8'h0a);
        rd(ADDR_WAKE_STAT, '{wake_input_state: 1'b1, default: '0}, 8'h01);
        rd(ADDR_IRQ_SRC, '{supply_overvoltage_flag: 1'b1, bus_fault: 4'h8, switch_fault: 4'h1,
           irq_source: 4'h3, default: '0}, 8'he3);
        $display("test status_reads done");

        // Reply uses the old enable, which clears only at chip select rise after the reply
        exp_ctrl.wake_input_enable = 1'b0;
        wr(ADDR_WAKE_CTRL, 4'h0, '{wake_input_state: 1'b1, default: '0}, 8'h01);
        rd(ADDR_WAKE_STAT, '{wake_input_state: 1'b1, default: '0}, 8'h00);
        exp_ctrl.bus_control = 4'hb;
        wr(ADDR_BUS_CTRL, 4'hb, '{bus_fault: 4'h1, default: '0}, 8'h41);
        exp_ctrl.switch_control = 4'h5;
        wr(ADDR_SW_CTRL, 4'h5, '{switch_fault: 4'h4, default: '0}, 8'h24);
        exp_ctrl.dog_period = 3'h5;
        wr(ADDR_TIMING, 4'h5, '{dog_status: 4'h8, default: '0}, 8'h08);
        exp_ctrl.cyclic_period = 3'h6;
        wr(ADDR_TIMING, 4'he, '0, 8'h00);
        exp_ctrl.analog_mux_control = 4'h9;
        wr(ADDR_MUX, 4'h9, '{dog_status: 4'hf, default: '0}, 8'h00);
        exp_ctrl.configuration = 2'h3;
        wr(ADDR_CONFIG, 4'hc, '{dog_status: 4'hf, default: '0}, 8'h00);
        exp_ctrl.interrupt_mask = 3'h5;
        wr(ADDR_IRQ_MASK, 4'h9, '{irq_source: 4'h6, default: '0}, 8'h06);
        $display("test control_writes done");

        for (int i = 0; i < 6; i++)
        begin
            wr(odd_a[i], 4'hf, '0, 8'h00);
        end
        xfer(ADDR_MODE, 4'hd, '0, 7, 4);
        cmp_ctrl(ctrl, exp_ctrl);
        xfer(ADDR_MODE, 4'hd, '0, 9, 4);
        cmp_ctrl(ctrl, exp_ctrl);
        cmp8({6'h0, mode}, 8'h00);
        exp_ctrl.overvoltage_shutdown_enable = 1'b1;
        exp_ctrl.bus_pullup_enable = 1'b1;
        xfer(ADDR_MODE, 4'hd, '0, 8, 6);
        cmp_ctrl(ctrl, exp_ctrl);
        cmp8({6'h0, mode}, 8'h01);
        $display("test refused_frames done");

        resetn = 1'b0;
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        repeat (4) @(negedge sys_clk);
        cmp_ctrl(ctrl, CTRL_RESET);
        rd(ADDR_VOLT, '0, 8'h81);
        $display("test second_reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
